// File: hw/sfm_master.sv
// Host-side master for a framed serial slave port, driven over APB.
// Assumes the slave is the only one on the bus and runs mode 0.
module sfm_master (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial pins
  output logic             sclk_o,
  output logic             mosi_o,
  output logic             sel_n_o,
  input  wire logic        miso_i,
  input  wire logic        attn_n_i,
  // Sleep control pin
  output logic             sleep_request_o
);

  typedef enum logic [3:0] {
    MS_IDLE = 4'b0001,
    MS_LOAD = 4'b0010,
    MS_WAIT = 4'b0100,
    MS_DONE = 4'b1000
  } sfm_ms_state_t;

  // Transmit frame builder phases
  typedef enum logic [4:0] {
    TX_START = 5'b00001,
    TX_LENH  = 5'b00010,
    TX_LENL  = 5'b00100,
    TX_DATA  = 5'b01000,
    TX_CSUM  = 5'b10000
  } sfm_tx_phase_t;

  typedef struct packed {
    sfm_ms_state_t state;
    sfm_tx_phase_t phase;
    logic          tx_act;
    logic [15:0]   tx_len;
    logic [15:0]   tx_left;
    logic [7:0]    tx_sum;
    logic          tx_full;
    logic [7:0]    tx_hold;
    logic          sleep;
    logic [7:0]    rx_data;
    logic          rx_vld;
    logic          rx_err;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          sel_n;
    logic          sleep_pin;
    logic          start;
    logic [7:0]    out_byte;
  } sfm_st_t;

  sfm_st_t st_r;
  sfm_st_t st_nxt;

  logic        sh_done;
  logic [7:0]  sh_rx;
  logic        sh_sclk;
  logic        sh_mosi;
  logic        pr_dvld;
  logic [7:0]  pr_data;
  logic        pr_ok;
  logic        pr_bad;
  logic        pr_in;
  logic [15:0] pr_rem;
  logic        attn_r;

  // ==========================================================================
  // Byte shifter and inbound parser
  sfm_shift #(
    .HALF_CYC (sfm_pkg::SCLK_HALF_CYC)
  ) u_shift (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .start_i   (st_r.start),
    .tx_byte_i (st_r.out_byte),
    .done_o    (sh_done),
    .rx_byte_o (sh_rx),
    .sclk_o    (sh_sclk),
    .mosi_o    (sh_mosi),
    .miso_i    (miso_i)
  );

  sfm_rx_frame u_rx (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .byte_vld_i (sh_done),
    .byte_i     (sh_rx),
    .data_vld_o (pr_dvld),
    .data_o     (pr_data),
    .end_ok_o   (pr_ok),
    .end_bad_o  (pr_bad),
    .in_frame_o (pr_in),
    .remain_o   (pr_rem)
  );

  // Attention sampled once; inputs are synchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      attn_r <= 1'b0;
    end else if (ce_i) begin
      attn_r <= ~attn_n_i;
    end
  end

  // ==========================================================================
  // Main next-state logic
  always_comb begin
    logic wr;
    logic rd;
    logic more;
    wr   = 1'b0;
    rd   = 1'b0;
    more = 1'b0;
    st_nxt         = st_r;
    st_nxt.start   = 1'b0;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;

    // APB: one wait cycle, answer in the access phase
    if (psel_i && penable_i && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      wr = pwrite_i;
      rd = !pwrite_i;
      st_nxt.prdata = 32'h0000_0000;
      case (paddr_i)
        sfm_pkg::REG_CTRL: begin
          if (wr) begin
            st_nxt.sleep = pwdata_i[sfm_pkg::CTRL_SLEEP];
            if (pwdata_i[sfm_pkg::CTRL_SEND] && !st_r.tx_act) begin
              st_nxt.tx_act  = 1'b1;
              st_nxt.phase   = TX_START;
              st_nxt.tx_left = st_r.tx_len;
              st_nxt.tx_sum  = 8'h00;
            end
          end
          st_nxt.prdata[sfm_pkg::CTRL_SLEEP] = st_r.sleep;
        end
        sfm_pkg::REG_STATUS: begin
          st_nxt.prdata[sfm_pkg::ST_BUSY]     = st_r.tx_act;
          st_nxt.prdata[sfm_pkg::ST_TXFREE]   = !st_r.tx_full;
          st_nxt.prdata[sfm_pkg::ST_RXVALID]  = st_r.rx_vld;
          st_nxt.prdata[sfm_pkg::ST_ATTN]     = attn_r;
          st_nxt.prdata[sfm_pkg::ST_RXERR]    = st_r.rx_err;
          st_nxt.prdata[sfm_pkg::ST_SELECTED] = !st_r.sel_n;
          // Error flag clears on read; a new error below wins
          if (rd) begin
            st_nxt.rx_err = 1'b0;
          end
        end
        sfm_pkg::REG_TXDATA: begin
          if (wr) begin
            st_nxt.tx_hold = pwdata_i[7:0];
            st_nxt.tx_full = 1'b1;
          end
        end
        sfm_pkg::REG_RXDATA: begin
          st_nxt.prdata = {23'h0, st_r.rx_vld, st_r.rx_data};
          if (rd) begin
            st_nxt.rx_vld = 1'b0;
          end
        end
        sfm_pkg::REG_LENGTH: begin
          if (wr && !st_r.tx_act) begin
            st_nxt.tx_len = pwdata_i[15:0];
          end
          st_nxt.prdata[15:0] = st_r.tx_len;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end

    // Received payload bytes; a bad checksum only raises the error flag
    if (pr_dvld) begin
      st_nxt.rx_data = pr_data;
      st_nxt.rx_vld  = 1'b1;
    end
    if (pr_bad) begin
      st_nxt.rx_err = 1'b1;
    end

    // Keep clocking while there is anything to move
    more = st_r.tx_act || attn_r || pr_in;

    // Serial sequencer
    case (st_r.state)
      MS_IDLE: begin
        if (more && !st_r.sleep) begin
          st_nxt.sel_n = 1'b0;
          st_nxt.state = MS_LOAD;
        end else begin
          st_nxt.sel_n = 1'b1;
        end
      end
      MS_LOAD: begin
        // Payload must be ready in time, else stall with select held
        st_nxt.out_byte = sfm_pkg::FILL_BYTE;
        if (st_r.tx_act) begin
          case (st_r.phase)
            TX_START: begin
              st_nxt.out_byte = sfm_pkg::FRAME_START;
              st_nxt.phase    = TX_LENH;
            end
            TX_LENH: begin
              st_nxt.out_byte = st_r.tx_len[15:8];
              st_nxt.phase    = TX_LENL;
            end
            TX_LENL: begin
              st_nxt.out_byte = st_r.tx_len[7:0];
              st_nxt.phase = (st_r.tx_len == 16'h0000) ? TX_CSUM : TX_DATA;
            end
            TX_DATA: begin
              // Consume only a written byte; a stall must not eat one
              if (st_r.tx_full) begin
                st_nxt.out_byte = st_r.tx_hold;
                // A write landing now refills the holder, so set wins
                if (!(wr && paddr_i == sfm_pkg::REG_TXDATA)) begin
                  st_nxt.tx_full = 1'b0;
                end
                st_nxt.tx_sum  = st_r.tx_sum + st_r.tx_hold;
                st_nxt.tx_left = st_r.tx_left - 16'h0001;
                if (st_r.tx_left == 16'h0001) begin
                  st_nxt.phase = TX_CSUM;
                end
              end
            end
            TX_CSUM: begin
              st_nxt.out_byte = sfm_pkg::CSUM_BASE - st_r.tx_sum;
              st_nxt.tx_act   = 1'b0;
            end
            default: st_nxt.phase = TX_START;
          endcase
        end
        // Stall mid frame rather than send a gap byte
        if (!(st_r.tx_act && st_r.phase == TX_DATA && !st_r.tx_full)) begin
          st_nxt.start = 1'b1;
          st_nxt.state = MS_WAIT;
        end
      end
      MS_WAIT: begin
        if (sh_done) begin
          st_nxt.state = MS_DONE;
        end
      end
      MS_DONE: begin
        // Parser has seen the byte now; decide whether to continue
        st_nxt.state = more ? MS_LOAD : MS_IDLE;
        if (!more) begin
          st_nxt.sel_n = 1'b1;
        end
      end
      default: st_nxt.state = MS_IDLE;
    endcase

    // Sleep pin drives high to sleep
    st_nxt.sleep_pin = st_r.sleep;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r       <= '0;
      st_r.state <= MS_IDLE;
      st_r.phase <= TX_START;
      st_r.sel_n <= 1'b1;
      st_r.sleep <= sfm_pkg::CTRL_RESET[sfm_pkg::CTRL_SLEEP];
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs; sclk and mosi are flops inside the shifter
  assign prdata_o        = st_r.prdata;
  assign pready_o        = st_r.pready;
  assign pslverr_o       = st_r.pslverr;
  assign sclk_o          = sh_sclk;
  assign mosi_o          = sh_mosi;
  assign sel_n_o         = st_r.sel_n;
  assign sleep_request_o = st_r.sleep_pin;

  // ==========================================================================
  // Checks
  AST_ATTN_SELECT : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && attn_r && !st_r.sleep && st_r.state == MS_IDLE)
    |=> !st_r.sel_n)
    else $error("attention not answered by select");

  AST_CLK_UNDER_SEL : assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    sh_sclk |-> !st_r.sel_n)
    else $error("clock toggles without select");

  AST_NO_DROP_ATTN : assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    (st_r.state == MS_DONE && attn_r) |=> st_r.state == MS_LOAD)
    else $error("stopped clocking while attention held");

  AST_START_BYTE : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_r.state == MS_LOAD && st_r.tx_act && st_r.phase == TX_START)
    |=> st_r.out_byte == sfm_pkg::FRAME_START)
    else $error("frame not opened by start byte");

  AST_FILL : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_r.state == MS_LOAD && !st_r.tx_act)
    |=> st_r.out_byte == sfm_pkg::FILL_BYTE)
    else $error("filler byte wrong");

  AST_SLEEP_PIN : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i |=> st_r.sleep_pin == $past(st_r.sleep))
    else $error("sleep pin does not follow control");

  AST_APB_ONE_WAIT : assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    (ce_i && psel_i && penable_i && !pready_o) |=> pready_o)
    else $error("apb answer late");

  AST_LEN_HOLD : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_r.tx_act && $stable(st_r.tx_act)) |-> $stable(st_r.tx_len))
    else $error("length changed during frame");

  COV_SEND   : cover property (@(posedge clk_i) st_r.phase == TX_CSUM);
  COV_ATTN   : cover property (@(posedge clk_i) attn_r && !st_r.sel_n);
  COV_RX_OK  : cover property (@(posedge clk_i) pr_ok);
  COV_RX_BAD : cover property (@(posedge clk_i) pr_bad);
  COV_RX_LONG : cover property (@(posedge clk_i) pr_in && pr_rem > 16'h0001);

endmodule : sfm_master

// File: hw/sfm_pkg.sv
// Constants shared by the framed serial master and its helpers.
// Assumes a 100 MHz system clock and a mode 0 slave on the far side.
package sfm_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SCLK_MAX_KHZ  = 4800;
  // Half period, rounded up so the wire never exceeds the ceiling
  localparam int unsigned SCLK_HALF_CYC =
    (CLK_HZ / 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

  // ==========================================================================
  // Framing
  localparam logic [7:0] FRAME_START  = 8'h7e;
  localparam logic [7:0] FILL_BYTE    = 8'hff;
  localparam logic [7:0] CSUM_BASE    = 8'hff;
  localparam int unsigned BYTE_BITS   = 8;

  // ==========================================================================
  // APB register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_TXDATA   = 8'h08;
  localparam logic [7:0] REG_RXDATA   = 8'h0c;
  localparam logic [7:0] REG_LENGTH   = 8'h10;

  // CTRL fields
  localparam int unsigned CTRL_SLEEP  = 0;
  localparam int unsigned CTRL_SEND   = 1;
  // STATUS fields
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_TXFREE   = 1;
  localparam int unsigned ST_RXVALID  = 2;
  localparam int unsigned ST_ATTN     = 3;
  localparam int unsigned ST_RXERR    = 4;
  localparam int unsigned ST_SELECTED = 5;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

endpackage : sfm_pkg

// File: hw/sfm_shift.sv
// Mode 0 byte shifter: makes sclk, shifts one byte out and in, MSB first.
// Assumes the caller keeps select low for the whole byte.
module sfm_shift #(
  parameter int unsigned HALF_CYC = sfm_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  // Byte request
  input  wire logic       start_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            done_o,
  output logic [7:0]      rx_byte_o,
  // Serial pins
  output logic            sclk_o,
  output logic            mosi_o,
  input  wire logic       miso_i
);

  initial begin
    // The half-period counter is eight bits wide
    if (HALF_CYC < 1 || HALF_CYC > 256) $error("HALF_CYC must be 1 to 256");
  end

  typedef struct packed {
    logic       busy;
    logic       sclk;
    logic [3:0] bits;
    logic [7:0] cnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       done;
  } sfm_shift_st_t;

  sfm_shift_st_t st_r;
  sfm_shift_st_t st_nxt;

  // ==========================================================================
  // Bit engine: rising edge samples, falling edge shifts the next bit
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy) begin
      if (start_i) begin
        st_nxt.busy = 1'b1;
        st_nxt.tx   = tx_byte_i;
        st_nxt.bits = 4'h0;
        st_nxt.cnt  = 8'h00;
      end
    end else if (st_r.cnt == 8'(HALF_CYC - 1)) begin
      st_nxt.cnt  = 8'h00;
      st_nxt.sclk = ~st_r.sclk;
      if (!st_r.sclk) begin
        st_nxt.rx = {st_r.rx[6:0], miso_i};
      end else begin
        st_nxt.tx   = {st_r.tx[6:0], 1'b0};
        st_nxt.bits = st_r.bits + 4'h1;
        if (st_r.bits == 4'h7) begin
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  // State register, clock idles low
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign done_o    = st_r.done;
  assign rx_byte_o = st_r.rx;
  assign sclk_o    = st_r.sclk;
  assign mosi_o    = st_r.tx[7];

  AST_IDLE_LOW : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !st_r.busy |-> !st_r.sclk)
    else $error("sclk not low while idle");

endmodule : sfm_shift

// File: hw/sfm_rx_frame.sv
// Inbound frame parser: hunts for start, length, payload and checksum.
// Assumes one byte per strobe; payload bytes pass on before the checksum is checked.
module sfm_rx_frame (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  // Byte stream
  input  wire logic       byte_vld_i,
  input  wire logic [7:0] byte_i,
  // Parsed output
  output logic            data_vld_o,
  output logic [7:0]      data_o,
  output logic            end_ok_o,
  output logic            end_bad_o,
  output logic            in_frame_o,
  output logic [15:0]     remain_o
);

  typedef enum logic [4:0] {
    PR_HUNT = 5'b00001,
    PR_LENH = 5'b00010,
    PR_LENL = 5'b00100,
    PR_DATA = 5'b01000,
    PR_CSUM = 5'b10000
  } sfm_pr_state_t;

  typedef struct packed {
    sfm_pr_state_t state;
    logic [15:0]   len;
    logic [7:0]    sum;
    logic          dvld;
    logic [7:0]    data;
    logic          ok;
    logic          bad;
  } sfm_pr_st_t;

  sfm_pr_st_t st_r;
  sfm_pr_st_t st_nxt;

  // ==========================================================================
  // Parser; outside a frame everything but the start byte is dropped
  always_comb begin
    st_nxt      = st_r;
    st_nxt.dvld = 1'b0;
    st_nxt.ok   = 1'b0;
    st_nxt.bad  = 1'b0;
    if (byte_vld_i) begin
      case (st_r.state)
        PR_HUNT: begin
          if (byte_i == sfm_pkg::FRAME_START) begin
            st_nxt.state = PR_LENH;
          end
        end
        PR_LENH: begin
          st_nxt.len[15:8] = byte_i;
          st_nxt.state     = PR_LENL;
        end
        PR_LENL: begin
          st_nxt.len[7:0] = byte_i;
          st_nxt.sum      = 8'h00;
          st_nxt.state    = ({st_r.len[15:8], byte_i} == 16'h0000) ?
                            PR_CSUM : PR_DATA;
        end
        PR_DATA: begin
          st_nxt.sum  = st_r.sum + byte_i;
          st_nxt.dvld = 1'b1;
          st_nxt.data = byte_i;
          st_nxt.len  = st_r.len - 16'h0001;
          if (st_r.len == 16'h0001) begin
            st_nxt.state = PR_CSUM;
          end
        end
        PR_CSUM: begin
          // Checksum is base minus payload sum
          st_nxt.ok    = (byte_i == sfm_pkg::CSUM_BASE - st_r.sum);
          st_nxt.bad   = (byte_i != sfm_pkg::CSUM_BASE - st_r.sum);
          st_nxt.state = PR_HUNT;
        end
        default: st_nxt.state = PR_HUNT;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r       <= '0;
      st_r.state <= PR_HUNT;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign data_vld_o = st_r.dvld;
  assign data_o     = st_r.data;
  assign end_ok_o   = st_r.ok;
  assign end_bad_o  = st_r.bad;
  assign in_frame_o = (st_r.state != PR_HUNT);
  assign remain_o   = st_r.len;

  AST_OK_BAD : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(st_r.ok && st_r.bad))
    else $error("frame both good and bad");

endmodule : sfm_rx_frame

// File: tb/sfm_slave_model.sv
// Behavioural framed serial slave: mode 0, MSB first, attention line.
// Assumes the master makes sclk idling low and frames bursts with sel_n.
module sfm_slave_model (
  // Serial pins
  input  wire logic clk_i,
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  input  wire logic sel_n_i,
  output logic      miso_o,
  output logic      attn_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // State
  logic [7:0]  tx_q[$];
  logic [7:0]  frm_q[$];
  logic [7:0]  sh_in;
  logic [7:0]  sh_out;
  logic        drv = 1'b1;
  logic        tog = 1'b0;
  logic        cur = 1'b0;
  int          bitn = 0;
  int          fcnt = 0;
  logic [15:0] flen = 16'h0;
  initial attn_n_o = 1'b1;
  // Released line flips so a stale bit never reads as data
  always @(posedge clk_i) tog <= ~tog;
  assign miso_o = sel_n_i ? tog : drv;
  // Queue a byte; attention goes low at once
  task automatic put(input logic [7:0] b);
    tx_q.push_back(b);
    attn_n_o = 1'b0;
  endtask : put
  // Next byte, or the last bit again when nothing is queued
  task automatic load();
    cur = tx_q.size() != 0;
    sh_out = cur ? tx_q.pop_front() : {8{drv}};
    drv = sh_out[7];
  endtask : load
  // Frame hunt: bytes outside a frame are dropped
  task automatic got();
    if (fcnt == 0 && sh_in != 8'h7e) return;
    frm_q.push_back(sh_in);
    if (fcnt == 0) flen = 16'hffff;
    if (fcnt == 1) flen[15:8] = sh_in;
    if (fcnt == 2) flen[7:0] = sh_in;
    fcnt++;
    if (fcnt == flen + 4) fcnt = 0;
  endtask : got
  // First bit is ready as soon as select falls
  always @(negedge sel_n_i) begin
    bitn = 0;
    load();
  end
  // Slave only: sample on the master's rising edge
  always @(posedge sclk_i) if (!sel_n_i) begin
    sh_in = {sh_in[6:0], mosi_i};
    bitn++;
  end
  // Shift out on the falling edge
  always @(negedge sclk_i) if (!sel_n_i) begin
    if (bitn == 8) begin
      bitn = 0;
      if (cur && tx_q.size() == 0) attn_n_o = 1'b1;
      got();
      load();
    end else begin
      sh_out = sh_out << 1;
      drv = sh_out[7];
    end
  end
endmodule : sfm_slave_model

// File: tb/sfm_master_tb.sv
// Self-checking bench for the framed serial master over APB.
// Assumes the behavioural slave model stands on the serial pins.
module sfm_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Signals
  logic        clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, ck_r = 0;
  logic [7:0]  paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic        pready_o, pslverr_o, sclk_o, mosi_o, sel_n_o;
  logic        miso_i, attn_n_i, sleep_request_o;
  logic [64:0] note_q[$];
  logic [7:0]  wexp_q[$], pl[$];
  int          errors = 0, check_count = 0, cyc = 0;
  time         t_r = 0;
  sfm_master sfm_master_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ce_i(1'b1), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sclk_o(sclk_o), .mosi_o(mosi_o), .sel_n_o(sel_n_o), .miso_i(miso_i),
    .attn_n_i(attn_n_i), .sleep_request_o(sleep_request_o));
  sfm_slave_model sfm_slave_model_i (.clk_i(clk_i), .sclk_i(sclk_o),
    .mosi_i(mosi_o), .sel_n_i(sel_n_o), .miso_o(miso_i),
    .attn_n_o(attn_n_i));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // ========
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Hang guard, well above the longest frame sequence
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  // Bus answers against the oldest note: {slverr, mask, data}
  always @(posedge clk_i) if (psel_i && penable_i && pready_o === 1'b1
                             && ck_r) begin
    chk({31'h0, pslverr_o}, {31'h0, note_q[0][64]});
    chk(prdata_o & note_q[0][63:32], note_q[0][31:0]);
    void'(note_q.pop_front());
  end
  // Frame bytes the slave accepted against what was sent
  always @(posedge clk_i) if (sfm_slave_model_i.frm_q.size() != 0) begin
    chk(sfm_slave_model_i.frm_q.pop_front(), wexp_q.pop_front());
  end
  // Rising edges never closer than one 4.8 MHz period
  always @(posedge sclk_o) begin
    if (t_r != 0) chk({31'h0, ($time - t_r) >= 209}, 32'h1);
    t_r = $time;
  end
  // Clock is low whenever select is released
  always @(posedge sel_n_o) if (reset_n_i) chk({31'h0, sclk_o}, 32'h0);
  // ========
  // APB master: held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic ck,
                     input logic [64:0] e);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    ck_r     <= ck;
    if (ck) note_q.push_back(e);
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 65'h0);
  endtask : wr
  task automatic rdx(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b1, {1'b0, m, e});
  endtask : rdx
  // Status poll; never used for the clear-on-read error bit
  task automatic poll(input int b);
    do apb(1'b0, sfm_pkg::REG_STATUS, 32'h0, 1'b0, 65'h0);
    while (rd[b] !== 1'b1);
  endtask : poll
  // Select falls only after the last write's answer, so let it fall first
  task automatic wait_idle();
    repeat (2) @(posedge clk_i);
    while (sel_n_o !== 1'b1) @(posedge clk_i);
  endtask : wait_idle
  // Outbound frame of n random payload bytes
  task automatic send(input int n);
    logic [7:0] s, b;
    s = 8'h0;
    wexp_q.push_back(sfm_pkg::FRAME_START);
    wexp_q.push_back(8'(n >> 8));
    wexp_q.push_back(8'(n));
    wr(sfm_pkg::REG_LENGTH, 32'(n));
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      s += b;
      wexp_q.push_back(b);
      poll(sfm_pkg::ST_TXFREE);
      wr(sfm_pkg::REG_TXDATA, {24'h0, b});
      if (i == 0) wr(sfm_pkg::REG_CTRL, 32'h2);
    end
    wexp_q.push_back(sfm_pkg::CSUM_BASE - s);
    wait_idle();
  endtask : send
  // Inbound frame behind filler; bad flips the checksum low bit
  task automatic recv(input int n, input logic bad);
    logic [7:0] s, b;
    s = 8'h0;
    pl = {8'h00, 8'hff, 8'h7e, 8'(n >> 8), 8'(n)};
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      s += b;
      pl.push_back(b);
    end
    pl.push_back((sfm_pkg::CSUM_BASE - s) ^ {7'h0, bad});
    foreach (pl[i]) sfm_slave_model_i.put(pl[i]);
    for (int i = 0; i < n; i++) begin
      poll(sfm_pkg::ST_RXVALID);
      rdx(sfm_pkg::REG_RXDATA, 32'h1ff, {23'h0, 1'b1, pl[5 + i]});
    end
    wait_idle();
    rdx(sfm_pkg::REG_STATUS, 32'h10, {27'h0, bad, 4'h0});
  endtask : recv
  // ========
  // Main sequence
  initial begin
    void'($urandom(66337));
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdx(sfm_pkg::REG_CTRL, 32'hffff_ffff, sfm_pkg::CTRL_RESET);
    rdx(sfm_pkg::REG_STATUS, 32'h3f, 32'h2);
    apb(1'b1, 8'h14, 32'h5, 1'b1, {1'b1, 64'h0});
    apb(1'b0, 8'h14, 32'h0, 1'b1, {1'b1, 32'hffff_ffff, 32'h0});
    send(1);
    send(3);
    recv(2, 1'b0);
    recv(1, 1'b1);
    wr(sfm_pkg::REG_CTRL, 32'h1);
    rdx(sfm_pkg::REG_CTRL, 32'h1, 32'h1);
    chk({31'h0, sleep_request_o}, 32'h1);
    wr(sfm_pkg::REG_CTRL, 32'h0);
    rdx(sfm_pkg::REG_CTRL, 32'h1, 32'h0);
    chk({31'h0, sleep_request_o}, 32'h0);
    end_sim();
  end
endmodule : sfm_master_tb
